//--- vertex_alu_model.sv
`timescale 1ns/1ps
// ==========
// Far-side arithmetic unit, passes source 0 through
module vertex_alu_model (
	input wire logic ref_clk,
	input wire logic operand_valid_r,
	input wire logic [127:0] operand0,
	output logic [127:0] alu_result
);
	logic [127:0] last_r = '0;
	always_ff @(posedge ref_clk) begin
		if (operand_valid_r) begin
			last_r <= operand0;
		end
	end
	// Stale data is shown inverted so a sample outside the write cycle is caught
	assign alu_result = operand_valid_r ? operand0 : ~last_r;
endmodule

//--- vertex_operand_access.sv
`timescale 1ns/1ps
`include "vertex_operand_access_regs.svh"

module vertex_operand_access (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic attr_wr,
	input wire logic [3:0] attr_wr_idx,
	input wire logic [127:0] attr_wr_data,
	input wire logic param_wr,
	input wire logic [6:0] param_wr_idx,
	input wire logic [127:0] param_wr_data,
	input wire logic issue_valid,
	input wire logic [4:0] issue_opcode,
	input wire logic [1:0] src_file [3],
	input wire logic [6:0] src_idx [3],
	input wire logic [2:0] src_relative,
	input wire logic [2:0] src_is_scalar,
	input wire logic [2:0] src_swz_count [3],
	input wire logic [7:0] src_swizzle [3],
	input wire logic [2:0] operand_negate_flag,
	input wire logic [6:0] src_offset [3],
	input wire logic [2:0] src_offset_neg,
	input wire logic dst_file,
	input wire logic [3:0] dst_idx,
	input wire logic [3:0] component_write_mask,
	input wire logic [127:0] alu_result,
	output logic issue_ready,
	output logic program_start,
	output logic bad_opcode,
	output logic [127:0] operand_r [3],
	output logic [4:0] opcode_r,
	output logic operand_valid_r,
	output logic [7:0] param_base_index,
	output logic [3:0] result_written_r [`VOA_RESULT_COUNT],
	output logic [127:0] result_r [`VOA_RESULT_COUNT]
);

	// ==========================================
	// Storage
	logic [127:0] attr_mem [`VOA_ATTR_COUNT];
	logic [127:0] temp_mem [`VOA_TEMP_COUNT];
	logic [127:0] param_mem [`VOA_PARAM_COUNT];
	logic [7:0] base_r, base_nxt;
	logic start_r, start_nxt;
	vertex_operand_pkg::state_t state_r, state_nxt;
	logic [127:0] op_nxt [3];
	logic [4:0] opcode_nxt;
	logic valid_nxt;
	logic [3:0] wmask_r, wmask_nxt;
	logic dfile_r, dfile_nxt;
	logic [3:0] didx_r, didx_nxt;

	// Select one 32-bit component by a 2-bit selector
	function automatic logic [31:0] pick(input logic [127:0] v, input logic [1:0] s);
		pick = v[s*32 +: 32];
	endfunction

	function automatic logic is_known(input logic [4:0] op);
		is_known = (op <= 5'(vertex_operand_pkg::op_lit));
	endfunction

	// ==========================================
	// Attribute and parameter loading
	always_ff @(posedge ref_clk) begin
		if (attr_wr) begin
			attr_mem[attr_wr_idx] <= attr_wr_data;
		end
		if (param_wr && (param_wr_idx < 7'(`VOA_PARAM_COUNT))) begin
			param_mem[param_wr_idx] <= param_wr_data;
		end
	end

	always_comb begin
		start_nxt = attr_wr && (attr_wr_idx == `VOA_ATTR_POSITION);
	end

	assign program_start = start_r;
	assign param_base_index = base_r;
	assign issue_ready = state_r != vertex_operand_pkg::st_write;
	assign bad_opcode = issue_valid && issue_ready && !is_known(issue_opcode);

	// ==========================================
	// Operand fetch
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_src
			logic [127:0] raw;
			logic [127:0] swz;
			logic [7:0] sel;
			logic signed [9:0] rel;
			always_comb begin
				rel = src_offset_neg[g] ?
					10'($signed({2'h0, base_r})) - 10'($signed({3'h0, src_offset[g]})) :
					10'($signed({2'h0, base_r})) + 10'($signed({3'h0, src_offset[g]}));
				raw = 128'h0;
				case (src_file[g])
					2'h0: raw = attr_mem[src_idx[g][3:0]];
					2'h1: raw = (src_idx[g] < 7'(`VOA_TEMP_COUNT)) ?
						temp_mem[src_idx[g][3:0]] : 128'h0;
					2'h2: begin
						if (src_relative[g]) begin
							if (rel < 10'sh000 || rel >= 10'sh060) begin
								raw = 128'h0;
							end else begin
								raw = param_mem[rel[6:0]];
							end
						end else begin
							raw = (src_idx[g] < 7'(`VOA_PARAM_COUNT)) ?
								param_mem[src_idx[g]] : 128'h0;
						end
					end
					default: raw = 128'h0;
				endcase
				sel = src_swizzle[g];
				if (src_is_scalar[g]) begin
					sel = {4{src_swizzle[g][1:0]}};
				end else if (src_swz_count[g] == 3'h0) begin
					sel = `VOA_SWZ_IDENTITY;
				end else if (src_swz_count[g] == 3'h1) begin
					sel = {4{src_swizzle[g][1:0]}};
				end
				for (int i = 0; i < 4; i++) begin
					swz[i*32 +: 32] = pick(raw, sel[i*2 +: 2]);
					swz[i*32 + 31] = swz[i*32 + 31] ^ operand_negate_flag[g];
				end
				op_nxt[g] = (issue_valid && issue_ready) ? swz : operand_r[g];
			end
		end
	endgenerate

	// ==========================================
	// Sequencing
	always_comb begin
		state_nxt = state_r;
		opcode_nxt = opcode_r;
		valid_nxt = 1'b0;
		wmask_nxt = wmask_r;
		dfile_nxt = dfile_r;
		didx_nxt = didx_r;
		case (state_r)
			vertex_operand_pkg::st_idle, vertex_operand_pkg::st_fetch: begin
				if (issue_valid && is_known(issue_opcode)) begin
					state_nxt = vertex_operand_pkg::st_write;
					opcode_nxt = issue_opcode;
					valid_nxt = 1'b1;
					wmask_nxt = (component_write_mask == 4'h0) ? 4'hf : component_write_mask;
					dfile_nxt = dst_file;
					didx_nxt = dst_idx;
				end else begin
					state_nxt = vertex_operand_pkg::st_idle;
				end
			end
			vertex_operand_pkg::st_write: begin
				state_nxt = vertex_operand_pkg::st_fetch;
			end
			default: state_nxt = vertex_operand_pkg::st_idle;
		endcase
	end

	always_comb begin
		base_nxt = base_r;
		// Address load updates only the base index
		if (state_r == vertex_operand_pkg::st_write &&
			opcode_r == 5'(vertex_operand_pkg::op_address_index_load)) begin
			base_nxt = alu_result[7:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= vertex_operand_pkg::st_idle;
			opcode_r <= 5'h00;
			operand_valid_r <= 1'b0;
			wmask_r <= 4'h0;
			dfile_r <= 1'b0;
			didx_r <= 4'h0;
			base_r <= 8'h00;
			start_r <= 1'b0;
			for (int k = 0; k < 3; k++) begin
				operand_r[k] <= 128'h0;
			end
		end else begin
			state_r <= state_nxt;
			opcode_r <= opcode_nxt;
			operand_valid_r <= valid_nxt;
			wmask_r <= wmask_nxt;
			dfile_r <= dfile_nxt;
			didx_r <= didx_nxt;
			base_r <= base_nxt;
			start_r <= start_nxt;
			for (int k = 0; k < 3; k++) begin
				operand_r[k] <= op_nxt[k];
			end
		end
	end

	// ==========================================
	// Masked writeback
	logic [127:0] wb_data;
	logic wb_en;
	always_comb begin
		wb_data = alu_result;
		wb_en = (state_r == vertex_operand_pkg::st_write) &&
			(opcode_r != 5'(vertex_operand_pkg::op_address_index_load));
		if (opcode_r == 5'(vertex_operand_pkg::op_reciprocal) ||
			opcode_r == 5'(vertex_operand_pkg::op_inverse_sqrt) ||
			opcode_r == 5'(vertex_operand_pkg::op_dot3) ||
			opcode_r == 5'(vertex_operand_pkg::op_dot4)) begin
			wb_data = {4{alu_result[31:0]}};
		end
	end

	// Temporaries have no reset; software loads them before use
	always_ff @(posedge ref_clk) begin
		for (int c = 0; c < 4; c++) begin
			if (wb_en && dfile_r == 1'b0 && didx_r < 4'(`VOA_TEMP_COUNT) && wmask_r[c]) begin
				temp_mem[didx_r][c*32 +: 32] <= wb_data[c*32 +: 32];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int r = 0; r < `VOA_RESULT_COUNT; r++) begin
				result_r[r] <= 128'h0;
				result_written_r[r] <= 4'h0;
			end
		end else begin
			for (int r = 0; r < `VOA_RESULT_COUNT; r++) begin
				if (start_r) begin
					result_written_r[r] <= 4'h0;
				end
				for (int c = 0; c < 4; c++) begin
					if (wb_en && dfile_r && didx_r == 4'(r) && wmask_r[c]) begin
						result_r[r][c*32 +: 32] <= wb_data[c*32 +: 32];
						result_written_r[r][c] <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================
	// Checks
	// start follows attribute zero
	a_start_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		attr_wr && attr_wr_idx == 4'h0 |=> program_start) else $error("no start");
	sequence s_issue;
		issue_valid && issue_ready && is_known(issue_opcode);
	endsequence
	a_fixed_latency: assert property (@(posedge ref_clk) disable iff (rst)
		s_issue |=> operand_valid_r && !issue_ready) else $error("latency");
	a_arl_no_write: assert property (@(posedge ref_clk) disable iff (rst)
		opcode_r == 5'h00 |-> !wb_en) else $error("address load wrote");
	a_replicate_scalar: assert property (@(posedge ref_clk) disable iff (rst)
		wb_en && opcode_r == 5'h07 |-> wb_data[127:96] == wb_data[31:0]) else $error("rep");
	a_mask_full: assert property (@(posedge ref_clk) disable iff (rst)
		issue_valid && issue_ready && is_known(issue_opcode) && component_write_mask == 4'h0
		|=> wmask_r == 4'hf) else $error("mask");
	a_negate_sign: assert property (@(posedge ref_clk) disable iff (rst)
		operand_negate_flag[0] |-> gen_src[0].swz[31] != pick(gen_src[0].raw,
		gen_src[0].sel[1:0])[31]) else $error("neg");
	a_rel_zero: assert property (@(posedge ref_clk) disable iff (rst)
		src_file[0] == 2'h2 && src_relative[0] && gen_src[0].rel >= 10'sh060 |->
		gen_src[0].raw == 128'h0) else $error("range");
	a_result_idx: assert property (@(posedge ref_clk) disable iff (rst)
		wb_en && dfile_r && wmask_r[0] |=> result_written_r[didx_r][0]) else $error("res");

endmodule

//--- vertex_operand_access_regs.svh
`ifndef VERTEX_OPERAND_ACCESS_REGS_SVH
`define VERTEX_OPERAND_ACCESS_REGS_SVH

// ==========================================
// Register file sizes
`define VOA_ATTR_COUNT 16
`define VOA_TEMP_COUNT 12
`define VOA_PARAM_COUNT 96
`define VOA_RESULT_COUNT 15
`define VOA_PARAM_LAST 96

// ==========================================
// Attribute indices
`define VOA_ATTR_POSITION 4'h0
`define VOA_ATTR_WEIGHT 4'h1
`define VOA_ATTR_NORMAL 4'h2
`define VOA_ATTR_COLOR0 4'h3
`define VOA_ATTR_COLOR1 4'h4
`define VOA_ATTR_FOG 4'h5
`define VOA_ATTR_TEX0 4'h8

// ==========================================
// Offset limits and selectors
`define VOA_POS_OFFSET_MAX 7'h3f
`define VOA_NEG_OFFSET_MAX 7'h40
`define VOA_SWZ_IDENTITY 8'he4
`define VOA_RESET_WORD 32'h0000_0000

`endif

//--- vertex_operand_access_tb.sv
`timescale 1ns/1ps
`include "vertex_operand_access_regs.svh"
// ==========
// Stimulus and scoreboard
module vertex_operand_access_tb;
	logic ref_clk, rst, attr_wr, param_wr, issue_valid, dst_file;
	logic [3:0] attr_wr_idx, dst_idx, component_write_mask;
	logic [127:0] attr_wr_data, param_wr_data, alu_result;
	logic [6:0] param_wr_idx;
	logic [4:0] issue_opcode, opcode_r;
	logic [1:0] src_file [3];
	logic [6:0] src_idx [3], src_offset [3];
	logic [2:0] src_relative, src_is_scalar, operand_negate_flag, src_offset_neg;
	logic [2:0] src_swz_count [3];
	logic [7:0] src_swizzle [3];
	logic issue_ready, program_start, bad_opcode, operand_valid_r, pend;
	logic [127:0] operand_r [3];
	logic [7:0] param_base_index, base_m;
	logic [3:0] result_written_r [`VOA_RESULT_COUNT];
	logic [127:0] result_r [`VOA_RESULT_COUNT];
	logic [127:0] attr_m [16], tmp_m [12], par_m [96], res_m [15];
	logic [127:0] opq [$];
	logic [135:0] rq [$];
	logic [135:0] ent;
	int n_errors, compares, f, c;
	int offs [5] = '{63, -64, 0, -1, 5};
	int bases [4] = '{0, 33, 95, 200};

	vertex_operand_access vertex_operand_access_i (.*);
	vertex_alu_model vertex_alu_model_i (.ref_clk(ref_clk), .operand_valid_r(operand_valid_r),
		.operand0(operand_r[0]), .alu_result(alu_result));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic end_sim;
		if (n_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	function automatic logic [127:0] rnd;
		return {$urandom, $urandom, $urandom, $urandom};
	endfunction

	function automatic logic [127:0] fetch(logic [1:0] fl, int ix, logic rel, int off,
			logic [2:0] cnt, logic [7:0] s, logic ng);
		logic [127:0] r, o;
		int e, sel;
		e = (rel && fl == 2'h2) ? int'(base_m) + off : ix;
		r = fl == 2'h0 ? attr_m[e] : fl == 2'h1 ? tmp_m[e] : (e < 0 || e > 95) ? '0 : par_m[e];
		for (int i = 0; i < 4; i++) begin
			sel = cnt == 3'h0 ? i : (cnt == 3'h1 || cnt == 3'h5) ? int'(s[1:0]) : int'(s[2*i+:2]);
			o[32*i+:32] = r[32*sel+:32];
			o[32*i+31] = o[32*i+31] ^ ng;
		end
		return o;
	endfunction

	task automatic wr(logic p, int ix, logic [127:0] d);
		if (p) par_m[ix] = d;
		else attr_m[ix] = d;
		@(posedge ref_clk);
		param_wr <= p;
		attr_wr <= !p;
		param_wr_idx <= ix[6:0];
		attr_wr_idx <= ix[3:0];
		param_wr_data <= d;
		attr_wr_data <= d;
		@(posedge ref_clk);
		param_wr <= 1'b0;
		attr_wr <= 1'b0;
		@(negedge ref_clk);
		cmp({127'h0, program_start}, {127'h0, !p && ix == 0}, "start pulse");
	endtask

	task automatic issue(logic [4:0] op, logic [1:0] fl, int ix, logic rel, int off,
			logic [2:0] cnt, logic [7:0] s, logic ng, logic df, int di, logic [3:0] m);
		logic [127:0] o, a;
		o = fetch(fl, ix, rel, off, cnt, s, ng);
		a = (op >= 5'h05 && op <= 5'h08) ? {4{o[31:0]}} : o;
		opq.push_back(o);
		if (op == 5'h00) begin
			base_m = o[7:0];
			rq.push_back({8'h20, 120'h0, o[7:0]});
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (m == 4'h0 || m[k]) begin
					if (df) res_m[di][32*k+:32] = a[32*k+:32];
					else tmp_m[di][32*k+:32] = a[32*k+:32];
				end
			end
			rq.push_back({3'h0, ~df, di[3:0], df ? res_m[di] : 128'h0});
		end
		@(posedge ref_clk);
		issue_valid <= 1'b1;
		issue_opcode <= op;
		src_file[0] <= fl;
		src_idx[0] <= ix[6:0];
		src_relative <= {2'b00, rel};
		src_is_scalar <= {2'b00, cnt == 3'h5};
		src_offset[0] <= off < 0 ? 7'(-off) : 7'(off);
		src_offset_neg <= {2'b00, off < 0};
		src_swz_count[0] <= cnt;
		src_swizzle[0] <= s;
		operand_negate_flag <= {2'b00, ng};
		dst_file <= df;
		dst_idx <= di[3:0];
		component_write_mask <= m;
		@(posedge ref_clk);
		issue_valid <= 1'b0;
	endtask

	always @(negedge ref_clk) begin
		if (pend) begin
			ent = rq.pop_front();
			if (ent[135:132] == 4'h2) cmp({120'h0, param_base_index}, ent[127:0], "base");
			if (ent[135:132] == 4'h0) cmp(result_r[ent[131:128]], ent[127:0], "dest");
		end
		pend = 1'b0;
		if (operand_valid_r === 1'b1) begin
			pend = 1'b1;
			if (opq.size() == 0) cmp('1, '0, "extra operand");
			else cmp(operand_r[0], opq.pop_front(), "operand");
		end
	end

	initial begin
		repeat (8000) @(posedge ref_clk);
		n_errors++;
		end_sim();
	end

	initial begin
		{rst, attr_wr, param_wr, issue_valid, dst_file, pend} = 6'h20;
		{attr_wr_idx, dst_idx, component_write_mask, param_wr_idx, issue_opcode} = '0;
		{attr_wr_data, param_wr_data, src_relative, src_is_scalar} = '0;
		{operand_negate_flag, src_offset_neg, base_m} = '0;
		for (int k = 0; k < 3; k++) begin
			{src_file[k], src_idx[k], src_offset[k], src_swz_count[k], src_swizzle[k]} = '0;
		end
		for (int k = 0; k < 15; k++) res_m[k] = '0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		void'($urandom(32'h4c8b));
		for (int i = 0; i < 96; i++) wr(1'b1, i, rnd());
		for (int i = 0; i < 16; i++) wr(1'b0, i, rnd());
		for (int i = 0; i < 12; i++) issue(5'h01, 2'h0, i, 1'b0, 0, 3'h0, 8'h0, 1'b0, 1'b0, i, 4'h0);
		foreach (bases[b]) begin
			wr(1'b0, 6, {120'(rnd()), 8'(bases[b])});
			issue(5'h00, 2'h0, 6, 1'b0, 0, 3'h0, 8'h0, 1'b0, 1'b1, 0, 4'h0);
			foreach (offs[j]) issue(5'h01, 2'h2, 0, 1'b1, offs[j], 3'h4, 8'he4, 1'b0, 1'b1, j, 4'h0);
		end
		@(posedge ref_clk);
		issue_valid <= 1'b1;
		issue_opcode <= 5'h11;
		@(negedge ref_clk);
		cmp({127'h0, bad_opcode}, 128'h1, "bad opcode");
		@(posedge ref_clk);
		issue_valid <= 1'b0;
		for (int n = 0; n < 96; n++) begin
			f = $urandom % 3;
			c = $urandom % 4;
			// Any 4-bit mask lists components in ascending order
			issue(5'(1 + n % 16), 2'(f), f == 0 ? $urandom % 16 : f == 1 ? $urandom % 12 : $urandom % 96,
				1'($urandom), int'($urandom % 128) - 64,
				c == 3 ? 3'h5 : c == 2 ? 3'h4 : 3'(c), 8'($urandom),
				1'($urandom), n[0], n[0] ? $urandom % 15 : $urandom % 12, 4'($urandom));
		end
		repeat (3) @(posedge ref_clk);
		end_sim();
	end
endmodule

//--- vertex_operand_pkg.sv
package vertex_operand_pkg;
	// Source register file
	typedef enum logic [1:0] {
		file_attr = 2'h0,
		file_temp = 2'h1,
		file_param = 2'h2
	} src_file_t;

	// Destination register file
	typedef enum logic {
		dst_temp = 1'b0,
		dst_result = 1'b1
	} dst_file_t;

	// Seventeen opcodes
	typedef enum logic [4:0] {
		op_address_index_load = 5'h00,
		op_mov = 5'h01,
		op_mul = 5'h02,
		op_add = 5'h03,
		op_mad = 5'h04,
		op_reciprocal = 5'h05,
		op_inverse_sqrt = 5'h06,
		op_dot3 = 5'h07,
		op_dot4 = 5'h08,
		op_dst = 5'h09,
		op_min = 5'h0a,
		op_max = 5'h0b,
		op_slt = 5'h0c,
		op_sge = 5'h0d,
		op_exp = 5'h0e,
		op_log = 5'h0f,
		op_lit = 5'h10
	} opcode_t;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_fetch = 3'b010,
		st_write = 3'b100
	} state_t;
endpackage
